// ===== core/scam_attr_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "scam_map.vh"
// combinational decode of one mapping entry against an incoming transaction
module scam_attr_decode (
  input wire [31:0] entry,
  input wire wide_en,
  input wire in_write,
  input wire in_instr,
  input wire in_priv,
  input wire bank_priv,
  input wire in_wa,
  input wire in_ra,
  input wire in_trans,
  input wire in_nsec,
  input wire [1:0] in_share,
  input wire [3:0] in_mattr,
  input wire [1:0] in_bar,
  output reg [1:0] kind,
  output wire grp_valid,
  output wire bcast,
  output reg [1:0] bar_dom,
  output wire o_instr,
  output wire o_priv,
  output wire o_wa,
  output wire o_ra,
  output wire o_trans,
  output wire o_nsec,
  output reg [1:0] o_share,
  output wire [3:0] o_mattr
);

  // codes 00 and reserved 01 keep the incoming value
  function ovr;
    input [1:0] code;
    input dflt;
    input va;
    input vb;
    begin
      if (code == `SCAM_OV_A) begin
        ovr = va;
      end else if (code == `SCAM_OV_B) begin
        ovr = vb;
      end else begin
        ovr = dflt; // RQ24
      end
    end
  endfunction

  wire byp = (kind == `SCAM_TY_BYP);
  wire xl = (kind == `SCAM_TY_XLAT);
  wire [1:0] barrier_domain_upgrade = entry[`SCAM_PV_HI:`SCAM_PV_LO];

  // reserved type code falls back to fault
  always @* begin
    case (entry[`SCAM_TY_HI:`SCAM_TY_LO])
      `SCAM_TY_XLAT: kind = `SCAM_TY_XLAT; // RQ1
      `SCAM_TY_BYP: kind = `SCAM_TY_BYP; // RQ1
      default: kind = `SCAM_TY_FLT; // RQ1
    endcase
  end

  // valid bit only counts while wide ids are enabled
  assign grp_valid = wide_en ? entry[`SCAM_XV] : 1'b1; // RQ11

  // writes are always data; fetch kind only for translation reads
  assign o_instr = in_write ? 1'b0 : // RQ4
    (xl ? ovr(entry[`SCAM_IN_HI:`SCAM_IN_LO], in_instr, 1'b0, 1'b1) : in_instr); // RQ3
  wire pv = xl ? ovr(entry[`SCAM_PV_HI:`SCAM_PV_LO], in_priv, 1'b0, 1'b1) : in_priv; // RQ5
  assign o_priv = pv | (xl & bank_priv); // RQ6
  assign o_trans = ovr(entry[`SCAM_TR_HI:`SCAM_TR_LO], in_trans, 1'b0, 1'b1); // RQ2
  assign o_wa = ovr(entry[`SCAM_WA_HI:`SCAM_WA_LO], in_wa, 1'b1, 1'b0); // RQ7
  assign o_ra = ovr(entry[`SCAM_RA_HI:`SCAM_RA_LO], in_ra, 1'b1, 1'b0); // RQ8
  assign o_nsec = ovr(entry[`SCAM_NS_HI:`SCAM_NS_LO], in_nsec, 1'b0, 1'b1); // RQ9
  assign o_mattr = entry[`SCAM_MT] ? entry[`SCAM_MA_HI:`SCAM_MA_LO] : in_mattr; // RQ10
  assign bcast = byp & entry[`SCAM_FB]; // RQ20

  // shareability override has all four codes defined
  always @* begin
    if (entry[`SCAM_SH_HI:`SCAM_SH_LO] == `SCAM_OV_DFLT) begin
      o_share = in_share;
    end else begin
      o_share = entry[`SCAM_SH_HI:`SCAM_SH_LO]; // RQ13
    end
  end

  // barrier domain never narrower than the requested minimum
  always @* begin
    if (byp && (barrier_domain_upgrade > in_bar)) begin
      bar_dom = barrier_domain_upgrade; // RQ21
    end else begin
      bar_dom = in_bar;
    end
  end

endmodule
`default_nettype wire

// ===== core/scam_top.v
// Functional notes
// RQ1: type field picks translation bank, bypass or fault; reserved code means fault.
// RQ2: transient field: zero default, two non-transient, three transient.
// RQ3: translation format fetch kind: zero default, two data, three instruction.
// RQ4: fetch kind never applies to writes; writes go out as data.
// RQ5: translation format privilege: zero default, two unprivileged, three privileged.
// RQ6: hypervisor or monitor bank traffic is marked privileged downstream.
// RQ7: write allocate: zero default, two allocate, three no allocate.
// RQ8: read allocate: zero default, two allocate, three no allocate.
// RQ9: security field exists only in secure groups; two secure, three non-secure.
// RQ10: memory-type bit selects default or the four-bit attribute field.
// RQ11: valid bit ignored unless wide ids enabled; else marks group valid.
// RQ12: without wide id support the valid bit is reserved.
// RQ13: shareability: zero default, one outer, two inner, three none.
// RQ14: bank select wide enough for all banks; spare bits read zero.
// RQ15: absent transient, allocation, shareability fields read zero, ignore writes.
// RQ16: secure translation entries point only at secure stage 1 banks.
// RQ17: non-secure entries point only at banks not reserved as secure.
// RQ18: uncached or device memory should use the advised no-allocate settings.
// RQ19: bypass does no translation, only attribute overlay.
// RQ20: bypass force-broadcast upgrades maintenance to inner shareable broadcast.
// RQ21: bypass barrier field sets minimum barrier domain; zero when unsupported.
// RQ22: entries are 32-bit read-write, unknown at reset; missing ones read zero.
// RQ23: a fault context raises an invalid context fault; not while wide ids are enabled, as the fault format drops the valid bit.
// RQ24: a reserved attribute code acts as the default selection.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "scam_map.vh"
module scam_top #(
  parameter NUM_ENTRIES = 8,
  parameter CB_BITS = 4,
  parameter HAS_TRANS = 1,
  parameter HAS_ALLOC = 1,
  parameter HAS_SHARE = 1,
  parameter HAS_BSU = 1,
  parameter WIDE_SUP = 1
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`SCAM_AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_r,
  output reg pready_r,
  output reg pslverr_r,
  input wire txn_valid,
  input wire [7:0] txn_group,
  input wire txn_write,
  input wire txn_instr,
  input wire txn_priv,
  input wire hypervisor_bank_flag,
  input wire monitor_bank_flag,
  input wire txn_wa,
  input wire txn_ra,
  input wire txn_trans,
  input wire txn_nsec,
  input wire [1:0] txn_share,
  input wire [3:0] txn_mattr,
  input wire txn_maint,
  input wire [1:0] txn_bar,
  output reg out_valid_r,
  output reg [1:0] out_kind_r,
  output reg [7:0] out_cb_r,
  output reg out_grp_valid_r,
  output reg out_fault_r,
  output reg out_bcast_r,
  output reg [1:0] out_bar_r,
  output reg out_instr_r,
  output reg out_priv_r,
  output reg out_wa_r,
  output reg out_ra_r,
  output reg out_trans_r,
  output reg out_nsec_r,
  output reg [1:0] out_share_r,
  output reg [3:0] out_mattr_r
);

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------

  // entry words carry no reset: software must program them; control and fault count reset to zero
  reg [31:0] map_mem [0:NUM_ENTRIES-1];
  reg [31:0] ctrl_r;
  reg [`SCAM_FCNT_W-1:0] fcnt_r;
  reg [`SCAM_FCNT_W-1:0] fcnt_nxt;

  wire wide_en = ctrl_r[`SCAM_C_WIDE_EN] & (WIDE_SUP != 0);
  wire [7:0] sec_cnt = ctrl_r[`SCAM_C_SEC_HI:`SCAM_C_SEC_LO];

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------

  wire setup = psel & ~penable;
  wire wr_go = psel & penable & pready_r & pwrite;
  wire in_win = (paddr[`SCAM_ENT_WIN_HI:`SCAM_ENT_WIN_LO] == `SCAM_ENT_WIN);
  wire [7:0] a_idx = paddr[`SCAM_IDX_HI:`SCAM_IDX_LO];
  wire a_impl = in_win & (a_idx < NUM_ENTRIES);
  wire a_ctrl = (paddr == `SCAM_CTRL_OFS);
  wire a_fcnt = (paddr == `SCAM_FCNT_OFS);
  wire a_map = in_win | a_ctrl | a_fcnt;

  // ------------------------------------------------------------
  // writable-bit mask of an entry
  // ------------------------------------------------------------

  // mask depends on the format being written and the group's security
  function [31:0] ent_mask;
    input [1:0] ty;
    input sec_grp;
    reg [31:0] m;
    begin
      m = `SCAM_ENT_MASK;
      if (HAS_TRANS == 0) begin
        m[`SCAM_TR_HI:`SCAM_TR_LO] = 2'h0; // RQ15
      end
      if (HAS_ALLOC == 0) begin
        m[`SCAM_WA_HI:`SCAM_RA_LO] = 4'h0; // RQ15
      end
      if (HAS_SHARE == 0) begin
        m[`SCAM_SH_HI:`SCAM_SH_LO] = 2'h0; // RQ15
      end
      if (!sec_grp) begin
        m[`SCAM_NS_HI:`SCAM_NS_LO] = 2'h0; // RQ9
      end
      if (WIDE_SUP == 0) begin
        m[`SCAM_XV] = 1'b0; // RQ12
      end
      m[`SCAM_CB_HI:0] = (8'h01 << CB_BITS) - 8'h01; // RQ14
      if (ty == `SCAM_TY_BYP) begin
        m[`SCAM_IN_HI] = 1'b0;
        m[`SCAM_CB_HI:0] = 8'h00;
        if (HAS_BSU == 0) begin
          m[`SCAM_PV_HI:`SCAM_PV_LO] = 2'h0; // RQ21
        end
      end else if (ty != `SCAM_TY_XLAT) begin
        m = `SCAM_FLT_MASK; // fault format keeps only its type
      end
      ent_mask = m;
    end
  endfunction

  // ------------------------------------------------------------
  // entry array writes
  // ------------------------------------------------------------

  genvar gi;
  generate
    for (gi = 0; gi < NUM_ENTRIES; gi = gi + 1) begin : g_ent
      // write lands only at the completing access edge
      always @(posedge pclk) begin
        if (wr_go && a_impl && (a_idx == gi)) begin
          map_mem[gi] <= pwdata & // RQ22
            ent_mask(pwdata[`SCAM_TY_HI:`SCAM_TY_LO], gi < sec_cnt);
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------

  // secure group count and the wide-id enable steer the decode; the global override bit is stored only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `SCAM_CTRL_RST;
    end else if (wr_go && a_ctrl) begin
      ctrl_r <= pwdata & `SCAM_CTRL_WMASK;
    end
  end

  // ------------------------------------------------------------
  // apb response
  // ------------------------------------------------------------

  // read data is captured in setup so it leaves a flop; one access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      pready_r <= 1'b1;
      pslverr_r <= ~a_map;
      prdata_r <= 32'h0000_0000;
      if (!pwrite) begin
        if (a_impl) begin
          prdata_r <= map_mem[a_idx[2:0] % NUM_ENTRIES]; // RQ22
        end else if (a_ctrl) begin
          prdata_r <= ctrl_r;
          prdata_r[`SCAM_C_WIDE_SUP] <= (WIDE_SUP != 0); // RQ12
        end else if (a_fcnt) begin
          prdata_r <= {{(32-`SCAM_FCNT_W){1'b0}}, fcnt_r};
        end
      end
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // transaction lookup
  // ------------------------------------------------------------

  // groups past the implemented count see an all-zero word
  wire t_impl = (txn_group < NUM_ENTRIES);
  wire [31:0] t_raw = t_impl ? map_mem[txn_group[2:0] % NUM_ENTRIES] : 32'h0000_0000;
  wire t_sec = (txn_group < sec_cnt);
  wire [31:0] t_ent = t_raw & ent_mask(t_raw[`SCAM_TY_HI:`SCAM_TY_LO], t_sec);

  wire [1:0] d_kind;
  wire d_valid;
  wire d_bcast;
  wire [1:0] d_bar;
  wire d_instr;
  wire d_priv;
  wire d_wa;
  wire d_ra;
  wire d_trans;
  wire d_nsec;
  wire [1:0] d_share;
  wire [3:0] d_mattr;

  // decode of the selected group's entry
  scam_attr_decode u_dec (
    .entry(t_ent),
    .wide_en(wide_en),
    .in_write(txn_write),
    .in_instr(txn_instr),
    .in_priv(txn_priv),
    .bank_priv(hypervisor_bank_flag | monitor_bank_flag),
    .in_wa(txn_wa),
    .in_ra(txn_ra),
    .in_trans(txn_trans),
    .in_nsec(txn_nsec),
    .in_share(txn_share),
    .in_mattr(txn_mattr),
    .in_bar(txn_bar),
    .kind(d_kind),
    .grp_valid(d_valid),
    .bcast(d_bcast),
    .bar_dom(d_bar),
    .o_instr(d_instr),
    .o_priv(d_priv),
    .o_wa(d_wa),
    .o_ra(d_ra),
    .o_trans(d_trans),
    .o_nsec(d_nsec),
    .o_share(d_share),
    .o_mattr(d_mattr)
  );

  wire d_fault = txn_valid & (d_kind == `SCAM_TY_FLT) & d_valid;

  // ------------------------------------------------------------
  // registered result
  // ------------------------------------------------------------

  // one cycle from request to marked result; bypass gets no bank index
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid_r <= 1'b0;
      out_kind_r <= `SCAM_TY_FLT;
      out_cb_r <= 8'h00;
      out_grp_valid_r <= 1'b0;
      out_fault_r <= 1'b0;
      out_bcast_r <= 1'b0;
      out_bar_r <= 2'h0;
      out_instr_r <= 1'b0;
      out_priv_r <= 1'b0;
      out_wa_r <= 1'b0;
      out_ra_r <= 1'b0;
      out_trans_r <= 1'b0;
      out_nsec_r <= 1'b0;
      out_share_r <= 2'h0;
      out_mattr_r <= 4'h0;
    end else begin
      out_valid_r <= txn_valid;
      out_fault_r <= d_fault; // RQ23
      if (txn_valid) begin
        out_kind_r <= d_kind; // RQ1
        out_grp_valid_r <= d_valid; // RQ11
        if (d_kind == `SCAM_TY_XLAT) begin
          out_cb_r <= t_ent[`SCAM_CB_HI:0]; // RQ14
        end else begin
          out_cb_r <= 8'h00; // RQ19
        end
        out_bcast_r <= d_bcast & txn_maint; // RQ20
        out_bar_r <= d_bar; // RQ21
        out_instr_r <= d_instr; // RQ4
        out_priv_r <= d_priv; // RQ6
        out_wa_r <= d_wa;
        out_ra_r <= d_ra;
        out_trans_r <= d_trans;
        out_nsec_r <= d_nsec;
        out_share_r <= d_share;
        out_mattr_r <= d_mattr; // RQ10
      end
    end
  end

  // ------------------------------------------------------------
  // fault counter
  // ------------------------------------------------------------

  // a fault in the clearing cycle still counts, so none is lost
  always @* begin
    fcnt_nxt = fcnt_r;
    if (wr_go && a_fcnt) begin
      fcnt_nxt = {`SCAM_FCNT_W{1'b0}};
    end
    if (d_fault && (fcnt_nxt != {`SCAM_FCNT_W{1'b1}})) begin
      fcnt_nxt = fcnt_nxt + {{(`SCAM_FCNT_W-1){1'b0}}, 1'b1}; // RQ23
    end
  end

  // saturates rather than wrapping
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcnt_r <= {`SCAM_FCNT_W{1'b0}};
    end else begin
      fcnt_r <= fcnt_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== shared/scam_map.vh
`ifndef SCAM_MAP_VH
`define SCAM_MAP_VH
// apb map (byte addresses)
`define SCAM_AW 12
`define SCAM_ENT_WIN_HI 11
`define SCAM_ENT_WIN_LO 10
`define SCAM_ENT_WIN 2'h0
`define SCAM_CTRL_OFS 12'h800
`define SCAM_FCNT_OFS 12'h804
`define SCAM_IDX_HI 9
`define SCAM_IDX_LO 2
// control register fields
`define SCAM_C_WIDE_EN 0
`define SCAM_C_GOVR_EN 1
`define SCAM_C_WIDE_SUP 8
`define SCAM_C_SEC_HI 23
`define SCAM_C_SEC_LO 16
`define SCAM_CTRL_RST 32'h0000_0000
`define SCAM_CTRL_WMASK 32'h00ff_0003
// mapping entry fields
`define SCAM_IMP_HI 31
`define SCAM_IMP_LO 30
`define SCAM_TR_HI 29
`define SCAM_TR_LO 28
`define SCAM_IN_HI 27
`define SCAM_IN_LO 26
`define SCAM_FB 26
`define SCAM_PV_HI 25
`define SCAM_PV_LO 24
`define SCAM_WA_HI 23
`define SCAM_WA_LO 22
`define SCAM_RA_HI 21
`define SCAM_RA_LO 20
`define SCAM_NS_HI 19
`define SCAM_NS_LO 18
`define SCAM_TY_HI 17
`define SCAM_TY_LO 16
`define SCAM_MA_HI 15
`define SCAM_MA_LO 12
`define SCAM_MT 11
`define SCAM_XV 10
`define SCAM_SH_HI 9
`define SCAM_SH_LO 8
`define SCAM_CB_HI 7
// writable bits before per-format trimming, and the fault-format keep mask
`define SCAM_ENT_MASK 32'h3fff_ffff
`define SCAM_FLT_MASK 32'h0003_0000
// context type codes
`define SCAM_TY_XLAT 2'h0
`define SCAM_TY_BYP 2'h1
`define SCAM_TY_FLT 2'h2
// override codes of two-bit fields
`define SCAM_OV_DFLT 2'h0
`define SCAM_OV_A 2'h2
`define SCAM_OV_B 2'h3
// shareability codes (field and port)
`define SCAM_SH_OUT 2'h1
`define SCAM_SH_INN 2'h2
`define SCAM_SH_NON 2'h3
`define SCAM_FCNT_W 16
`endif

// ===== sim/scam_sink.sv
`timescale 1ns/1ps
`default_nettype none
// downstream interconnect: takes each marked transaction as it is offered
module scam_sink (
  input wire logic pclk,
  input wire logic dv,
  input wire logic [26:0] dn,
  output logic [26:0] got
);
  // keeps the last accepted word; no back-pressure, the lookup path has none
  always @(posedge pclk) begin
    if (dv) begin
      got <= dn;
    end
  end
endmodule
`default_nettype wire

// ===== sim/scam_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "scam_map.vh"
module scam_top_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready_r,
  input wire logic txn_valid,
  input wire logic txn_write,
  input wire logic txn_maint,
  input wire logic [1:0] txn_bar,
  input wire logic hypervisor_bank_flag,
  input wire logic monitor_bank_flag,
  input wire logic out_valid_r,
  input wire logic [1:0] out_kind_r,
  input wire logic [7:0] out_cb_r,
  input wire logic out_grp_valid_r,
  input wire logic out_fault_r,
  input wire logic out_bcast_r,
  input wire logic [1:0] out_bar_r,
  input wire logic out_instr_r,
  input wire logic out_priv_r
);
  default clocking dck @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // register access and lookup timing
  // ------------------------------------------------------------
  apb_one_wait_a: assert property (psel && !penable |=> pready_r ##1 !pready_r)
    else $error("register access not answered in its access cycle");
  lookup_latency_a: assert property (out_valid_r == $past(txn_valid))
    else $error("lookup answer not one cycle after request");
  result_holds_a: assert property (!txn_valid |=> $stable(out_kind_r) && $stable(out_priv_r))
    else $error("lookup result changed without a request");
  // ------------------------------------------------------------
  // attribute decode
  // ------------------------------------------------------------
  write_is_data_a: assert property (txn_valid && txn_write |=> !out_instr_r)
    else $error("write marked as instruction fetch");
  bank_priv_a: assert property (txn_valid && (hypervisor_bank_flag || monitor_bank_flag)
    |=> out_kind_r != `SCAM_TY_XLAT || out_priv_r)
    else $error("hypervisor or monitor bank traffic not privileged");
  // in a valid group's answer the fault flag stands exactly beside a fault-kind answer
  fault_raise_a: assert property (out_valid_r && out_grp_valid_r
    |-> out_fault_r == (out_kind_r == `SCAM_TY_FLT))
    else $error("fault flag disagrees with context kind");
  fault_pulse_a: assert property (out_fault_r |-> out_valid_r)
    else $error("fault flag outside a lookup answer");
  no_bank_a: assert property (out_valid_r && out_kind_r != `SCAM_TY_XLAT |-> out_cb_r == 8'h00)
    else $error("bank index given for bypass or fault");
  bcast_cause_a: assert property (txn_valid && !txn_maint |=> !out_bcast_r)
    else $error("broadcast upgrade on non-maintenance traffic");
  barrier_floor_a: assert property (txn_valid |=> out_bar_r >= $past(txn_bar))
    else $error("barrier domain lowered");
  cover property (out_fault_r);
  cover property (out_valid_r && out_bcast_r);
  cover property (out_valid_r && !out_grp_valid_r);
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata_r, rd;
  logic pready_r, pslverr_r, se, txn_valid = 1'b0, txn_write = 1'b0, txn_instr = 1'b0;
  logic txn_priv = 1'b0, hypervisor_bank_flag = 1'b0, monitor_bank_flag = 1'b0, txn_wa = 1'b0;
  logic txn_ra = 1'b0, txn_trans = 1'b0, txn_nsec = 1'b0, txn_maint = 1'b0;
  logic [1:0] txn_share = 2'h0, txn_bar = 2'h0, out_kind_r, out_bar_r, out_share_r;
  logic [3:0] txn_mattr = 4'h0, out_mattr_r;
  logic [7:0] txn_group = 8'h00, out_cb_r;
  logic out_valid_r, out_grp_valid_r, out_fault_r, out_bcast_r, out_instr_r, out_priv_r;
  logic out_wa_r, out_ra_r, out_trans_r, out_nsec_r;
  logic [26:0] got;
  int err_count = 0, total_checks = 0;
  localparam logic [26:0] ALL = 27'h7ff_ffff, TOP = 27'h7ff_8000;
  always #4 pclk = ~pclk;
  scam_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_r,
    .pready_r, .pslverr_r, .txn_valid, .txn_group, .txn_write, .txn_instr, .txn_priv,
    .hypervisor_bank_flag, .monitor_bank_flag, .txn_wa, .txn_ra, .txn_trans, .txn_nsec,
    .txn_share, .txn_mattr, .txn_maint, .txn_bar, .out_valid_r, .out_kind_r, .out_cb_r,
    .out_grp_valid_r, .out_fault_r, .out_bcast_r, .out_bar_r, .out_instr_r, .out_priv_r,
    .out_wa_r, .out_ra_r, .out_trans_r, .out_nsec_r, .out_share_r, .out_mattr_r);
  scam_sink u_sink (.pclk(pclk), .dv(out_valid_r), .got(got), .dn({out_kind_r, out_cb_r,
    out_grp_valid_r, out_fault_r, out_bcast_r, out_bar_r, out_instr_r, out_priv_r, out_wa_r,
    out_ra_r, out_trans_r, out_nsec_r, out_share_r, out_mattr_r}));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk_reg(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t reg got %h exp %h", $time, g, e);
    end
  endtask
  task chk_out(input logic [26:0] g, input logic [26:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t lookup got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer; holds the request until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready_r !== 1'b1);
    rd = prdata_r;
    se = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk_reg(rd, e);
  endtask
  // attribute word: write instr priv hyp mon wa ra trans nsec share mattr maint bar
  task look(input logic [7:0] g, input logic [17:0] a, input logic [26:0] e,
    input logic [26:0] m);
    @(posedge pclk);
    txn_valid <= 1'b1;
    txn_group <= g;
    {txn_write, txn_instr, txn_priv, hypervisor_bank_flag, monitor_bank_flag, txn_wa,
      txn_ra, txn_trans, txn_nsec, txn_share, txn_mattr, txn_maint, txn_bar} <= a;
    @(posedge pclk);
    txn_valid <= 1'b0;
    @(posedge pclk);
    #1;
    chk_out(got & m, e & m);
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk(12'h800, 32'h0000_0100);
    rchk(12'h804, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'hfffc_ffff);
    rchk(12'h000, 32'h3ff0_ff0f);
    apb(1'b1, 12'h004, 32'hffff_fffd);
    apb(1'b1, 12'h004, 32'hfffd_ffff);
    rchk(12'h004, 32'h37f1_ff00);
    apb(1'b1, 12'h008, 32'hffff_ffff);
    rchk(12'h008, 32'h0003_0000);
    apb(1'b1, 12'h020, 32'hffff_ffff);
    rchk(12'h020, 32'h0000_0000);
    rchk(12'h400, 32'h0000_0000);
    chk_reg({31'h0, se}, 32'h0000_0001);
    look(8'h00, 18'h1a86, 27'h1f_2cff, ALL);
    look(8'h00, 18'h2_1a86, 27'h1f_24ff, ALL);
    apb(1'b1, 12'h000, 32'h2aa0_0205);
    look(8'h00, 18'h1_8418, 27'hb_0323, ALL);
    look(8'h00, 18'h1_c418, 27'hb_0723, ALL);
    apb(1'b1, 12'h000, 32'h1550_0100);
    look(8'h00, 18'h1_37c8, 27'h1_0ed9, ALL);
    look(8'h01, 18'h1_1885, 27'h201_78bf, ALL);
    look(8'h02, 18'h0000, 27'h401_8000, TOP);
    rchk(12'h804, 32'h0000_0001);
    apb(1'b1, 12'h804, 32'h0000_0000);
    rchk(12'h804, 32'h0000_0000);
    // explicit fault code, not only the reserved one, must fault
    apb(1'b1, 12'h010, 32'h0002_0000);
    look(8'h04, 18'h0000, 27'h401_8000, TOP);
    apb(1'b1, 12'h800, 32'h0000_0001);
    apb(1'b1, 12'h00c, 32'h0000_0000);
    look(8'h03, 18'h0000, 27'h000_0000, TOP);
    apb(1'b1, 12'h00c, 32'h0000_0400);
    look(8'h03, 18'h0000, 27'h001_0000, TOP);
    apb(1'b1, 12'h800, 32'h0001_0000);
    // security field is kept and honoured in secure group 0, reads zero in non-secure group 1
    apb(1'b1, 12'h000, 32'h000c_0000);
    rchk(12'h000, 32'h000c_0000);
    apb(1'b1, 12'h004, 32'h000c_0000);
    rchk(12'h004, 32'h0000_0000);
    look(8'h00, 18'h0000, 27'h1_0040, ALL);
    apb(1'b1, 12'h000, 32'h0008_0000);
    look(8'h00, 18'h0200, 27'h1_0000, ALL);
    // global override on; uncached entry uses the advised hint settings
    apb(1'b1, 12'h800, 32'h0000_0002);
    rchk(12'h800, 32'h0000_0102);
    apb(1'b1, 12'h008, 32'h20f0_5900);
    look(8'h02, 18'h1c00, 27'h1_0015, ALL);
    end_of_test;
  end
  // watchdog, well beyond the roughly 140 cycles the tests need
  initial begin
    #200000;
    err_count++;
    end_of_test;
  end
endmodule
bind scam_top scam_top_asserts u_chk (.pclk, .presetn, .psel, .penable, .pready_r,
  .txn_valid, .txn_write, .txn_maint, .txn_bar, .hypervisor_bank_flag, .monitor_bank_flag,
  .out_valid_r, .out_kind_r, .out_cb_r, .out_grp_valid_r, .out_fault_r, .out_bcast_r,
  .out_bar_r, .out_instr_r, .out_priv_r);
`default_nettype wire
